// *** design/eeprom_slave.sv ***
/*
  Two-wire serial EEPROM slave: filtered bus sampling, byte protocol,
  page buffer and self-timed programming of the internal array.
  Assumes an external pull-up on sda and a board that ties unused select pins low.
*/
// Overview of operation
// - the array holds 1k bytes in the small variant and 2k in the others, 8 bits each.
// - one write transaction takes up to 16 data bytes, programmed together.
// - each read byte delivered moves the address pointer on by one.
// - programming of accepted data needs no further bus command.
// - incoming sda bits are sampled at the scl rising edge.
// - the driven sda bit changes only after an scl falling edge.
// - programming ends within 10 ms, and the master waits for it.
// - the 1k part matches only select pin 2, the plain 2k part matches no pin.
// - the three-pin variant takes a two-byte word address before data.
// - pulses on scl and sda shorter than the glitch reject width are ignored.
// - sda is only ever pulled low or released, never driven high.
// - the first byte after a start is type code, three select bits, direction.
// - write data is programmed only after the stop that ends the write.
// - the receiver pulls sda low on the ninth clock of each accepted byte as acknowledge, except the last byte of a read.
// - a write that ends while write protect is high modifies no location.
module eeprom_slave #(
  parameter logic [1:0] VARIANT      = eeprom_pkg::VAR_2K_WIDE,
  parameter logic [3:0] TYPE_CODE    = 4'h6,  // arbitrary value
  parameter int         WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // serial bus
  input  wire logic       i_scl,
  input  wire logic       i_sda_i,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  // straps and protection
  input  wire logic       i_select_pin_0,
  input  wire logic       i_select_pin_1,
  input  wire logic       i_select_pin_2,
  input  wire logic       i_write_protect,
  // status
  output logic            o_busy
);

  localparam int AW = eeprom_pkg::ADDR_W;
  localparam int DW = eeprom_pkg::DATA_W;
  localparam int EW = AW + DW;
  localparam int MEM_BYTES = (VARIANT == eeprom_pkg::VAR_1K) ?
                             eeprom_pkg::MEM_BYTES_SMALL : eeprom_pkg::MEM_BYTES_LARGE;

  typedef struct packed {
    eeprom_pkg::bus_state_type          st;
    eeprom_pkg::bus_state_type          after_ack;
    logic [DW-1:0]                      shift;
    logic [3:0]                         cnt;
    logic [AW-1:0]                      ptr;
    logic                               first;
    logic                               pushed;
    eeprom_pkg::line_type               prev;
    logic                               sda_oe;
    logic                               sda_o;
    logic                               prog;
    logic [eeprom_pkg::TIMER_W-1:0]     timer;
    logic                               wp_meta;
    logic                               wp_sync;
    logic [2:0]                         sel_meta;
    logic [2:0]                         sel_sync;
  } slave_state_type;

  slave_state_type          r_reg;
  slave_state_type          r_next;
  eeprom_pkg::line_type     raw;
  eeprom_pkg::line_type     c;
  logic [DW-1:0]            mem [0:MEM_BYTES-1];
  logic [DW-1:0]            rd_byte;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_seen;
  logic                     stop_seen;
  logic                     push_valid;
  logic                     push_ready;
  eeprom_pkg::wr_entry_type push_data;
  logic                     pop_valid;
  logic [EW-1:0]            pop_bits;
  eeprom_pkg::wr_entry_type pop_data;
  logic                     flush;

  function automatic logic [AW-1:0] mask_addr(input logic [AW-1:0] a);
    return a & AW'(MEM_BYTES - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin conditioning and page buffer

  assign raw = '{scl: i_scl, sda: i_sda_i};

  line_filter u_filter (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_raw   (raw),
    .o_clean (c)
  );

  sync_fifo #(
    .WIDTH (EW),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_page_buf (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_flush    (flush),
    .i_wr_valid (push_valid),
    .o_wr_ready (push_ready),
    .i_wr_data  (push_data),
    .o_rd_valid (pop_valid),
    .i_rd_ready (r_reg.prog),
    .o_rd_data  (pop_bits)
  );

  assign pop_data   = pop_bits;
  assign rd_byte    = mem[mask_addr(r_reg.ptr)];
  assign scl_rise   = c.scl & ~r_reg.prev.scl;
  assign scl_fall   = ~c.scl & r_reg.prev.scl;
  assign start_seen = c.scl & r_reg.prev.scl & r_reg.prev.sda & ~c.sda;
  assign stop_seen  = c.scl & r_reg.prev.scl & ~r_reg.prev.sda & c.sda;

  ////////////////////////////////////////////////////////////////////////////////
  // bus protocol and programming control

  always_comb begin
    logic                      ack;
    logic                      match;
    eeprom_pkg::bus_state_type nxt;
    logic [AW-1:0]             wa;
    ack        = 1'b0;
    match      = 1'b0;
    nxt        = eeprom_pkg::S_IDLE;
    wa         = r_reg.ptr;
    r_next     = r_reg;
    push_valid = 1'b0;
    push_data  = '{addr: r_reg.ptr, data: r_reg.shift};
    flush      = 1'b0;

    r_next.prev     = c;
    r_next.wp_meta  = i_write_protect;
    r_next.wp_sync  = r_reg.wp_meta;
    r_next.sel_meta = {i_select_pin_2, i_select_pin_1, i_select_pin_0};
    r_next.sel_sync = r_reg.sel_meta;
    r_next.sda_o    = 1'b0;

    // self-timed cycle: buffer drains first, then the timer runs out
    if (r_reg.prog) begin
      if (r_reg.timer == eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1) && !pop_valid) begin
        r_next.prog  = 1'b0;
        r_next.timer = '0;
      end else if (r_reg.timer != eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1)) begin
        r_next.timer = r_reg.timer + eeprom_pkg::TIMER_W'(1);
      end
    end

    if (start_seen) begin
      r_next.st     = eeprom_pkg::S_DEVADDR;
      r_next.cnt    = '0;
      r_next.sda_oe = 1'b0;
      r_next.pushed = 1'b0;
      // a write left without stop is dropped
      if (!r_reg.prog) begin
        flush = 1'b1;
      end
    end else if (stop_seen) begin
      r_next.st     = eeprom_pkg::S_IDLE;
      r_next.sda_oe = 1'b0;
      r_next.pushed = 1'b0;
      if (r_reg.pushed && !r_reg.prog) begin
        if (!r_reg.wp_sync) begin
          r_next.prog  = 1'b1;
          r_next.timer = '0;
        end else begin
          flush = 1'b1;
        end
      end
    end else begin
      case (r_reg.st)
        eeprom_pkg::S_DEVADDR,
        eeprom_pkg::S_ADDR_HI,
        eeprom_pkg::S_ADDR_LO,
        eeprom_pkg::S_WDATA: begin
          if (scl_rise && r_reg.cnt != eeprom_pkg::BITS_BYTE) begin
            r_next.shift = {r_reg.shift[DW-2:0], c.sda};
            r_next.cnt   = r_reg.cnt + 4'h1;
          end else if (scl_fall && r_reg.cnt == eeprom_pkg::BITS_BYTE) begin
            if (r_reg.st == eeprom_pkg::S_DEVADDR) begin
              if (VARIANT == eeprom_pkg::VAR_1K) begin
                match = (r_reg.shift[eeprom_pkg::SA_SEL_HI] == r_reg.sel_sync[2]);
                wa    = {1'b0, r_reg.shift[2:1], r_reg.ptr[7:0]};
              end else if (VARIANT == eeprom_pkg::VAR_2K) begin
                match = 1'b1;
                wa    = {r_reg.shift[3:1], r_reg.ptr[7:0]};
              end else begin
                match = (r_reg.shift[eeprom_pkg::SA_SEL_HI:eeprom_pkg::SA_SEL_LO]
                         == r_reg.sel_sync);
              end
              match = match && (r_reg.shift[eeprom_pkg::SA_TYPE_HI:eeprom_pkg::SA_TYPE_LO]
                                == TYPE_CODE);
              // polling during programming sees no acknowledge
              if (match && !r_reg.prog) begin
                ack        = 1'b1;
                r_next.ptr = mask_addr(wa);
                if (r_reg.shift[eeprom_pkg::SA_DIR] == eeprom_pkg::DIR_READ) begin
                  nxt = eeprom_pkg::S_TX;
                end else if (VARIANT == eeprom_pkg::VAR_2K_WIDE) begin
                  nxt = eeprom_pkg::S_ADDR_HI;
                end else begin
                  nxt = eeprom_pkg::S_ADDR_LO;
                end
              end
            end else if (r_reg.st == eeprom_pkg::S_ADDR_HI) begin
              ack        = 1'b1;
              r_next.ptr = mask_addr({r_reg.shift[2:0], r_reg.ptr[7:0]});
              nxt        = eeprom_pkg::S_ADDR_LO;
            end else if (r_reg.st == eeprom_pkg::S_ADDR_LO) begin
              ack          = 1'b1;
              r_next.ptr   = mask_addr({r_reg.ptr[AW-1:8], r_reg.shift});
              r_next.first = 1'b1;
              nxt          = eeprom_pkg::S_WDATA;
            end else if (push_ready) begin
              // a 17th byte finds the buffer full and is refused
              wa            = r_reg.first ? r_reg.ptr : eeprom_pkg::page_inc(r_reg.ptr);
              push_valid    = 1'b1;
              push_data     = '{addr: mask_addr(wa), data: r_reg.shift};
              r_next.ptr    = mask_addr(wa);
              r_next.first  = 1'b0;
              r_next.pushed = 1'b1;
              ack           = 1'b1;
              nxt           = eeprom_pkg::S_WDATA;
            end
            r_next.sda_oe    = ack;
            r_next.st        = ack ? eeprom_pkg::S_ACK : eeprom_pkg::S_IDLE;
            r_next.after_ack = nxt;
            r_next.cnt       = '0;
          end
        end
        eeprom_pkg::S_ACK: begin
          if (scl_fall) begin
            r_next.cnt = '0;
            r_next.st  = r_reg.after_ack;
            if (r_reg.after_ack == eeprom_pkg::S_TX) begin
              r_next.shift  = rd_byte;
              r_next.sda_oe = ~rd_byte[DW-1];
            end else begin
              r_next.sda_oe = 1'b0;
            end
          end
        end
        eeprom_pkg::S_TX: begin
          if (scl_fall) begin
            if (r_reg.cnt == eeprom_pkg::LAST_BIT) begin
              r_next.sda_oe = 1'b0;
              r_next.st     = eeprom_pkg::S_TX_ACK;
              r_next.ptr    = mask_addr(r_reg.ptr + AW'(1));
            end else begin
              r_next.cnt    = r_reg.cnt + 4'h1;
              r_next.shift  = {r_reg.shift[DW-2:0], 1'b0};
              r_next.sda_oe = ~r_reg.shift[DW-2];
            end
          end
        end
        eeprom_pkg::S_TX_ACK: begin
          if (scl_rise) begin
            // master acknowledge keeps the read going
            if (!c.sda) begin
              r_next.st        = eeprom_pkg::S_ACK;
              r_next.after_ack = eeprom_pkg::S_TX;
            end else begin
              r_next.st = eeprom_pkg::S_IDLE;
            end
          end
        end
        default: begin
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '{st: eeprom_pkg::S_IDLE, after_ack: eeprom_pkg::S_IDLE,
                 prev: 2'h3, wp_meta: 1'b1, wp_sync: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array update; overwrite stands for erase plus program
  always_ff @(posedge i_clk) begin
    if (r_reg.prog && pop_valid) begin
      mem[mask_addr(pop_data.addr)] <= pop_data.data;
    end
  end

  assign o_sda_o  = r_reg.sda_o;
  assign o_sda_oe = r_reg.sda_oe;
  assign o_busy   = r_reg.prog;

endmodule

// *** design/eeprom_pkg.sv ***
/*
  Shared constants, types and helpers for the two-wire serial EEPROM slave.
  Assumes a 50 MHz system clock; the bus lines are sampled, never used as clocks.
*/
package eeprom_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // array geometry
  localparam int MEM_BYTES_SMALL = 1024;
  localparam int MEM_BYTES_LARGE = 2048;
  localparam int ADDR_W          = 11;
  localparam int DATA_W          = 8;
  localparam int PAGE_BYTES      = 16;
  localparam int PAGE_W          = 4;
  localparam int FIFO_DEPTH      = PAGE_BYTES;

  ////////////////////////////////////////////////////////////////////////////////
  // variants
  localparam logic [1:0] VAR_1K      = 2'h0;
  localparam logic [1:0] VAR_2K      = 2'h1;
  localparam logic [1:0] VAR_2K_WIDE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // slave address byte layout
  localparam int         SA_TYPE_HI = 7;
  localparam int         SA_TYPE_LO = 4;
  localparam int         SA_SEL_HI  = 3;
  localparam int         SA_SEL_LO  = 1;
  localparam int         SA_DIR     = 0;
  localparam logic       DIR_READ   = 1'b1;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int GLITCH_NS     = 50;
  localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_MS      = 10;
  localparam int WRITE_CYCLES  = (WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 20;
  localparam int GLITCH_CW     = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_entry_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_type;

  typedef enum logic [2:0] {
    S_IDLE    = 3'h0,
    S_DEVADDR = 3'h1,
    S_ADDR_HI = 3'h2,
    S_ADDR_LO = 3'h3,
    S_WDATA   = 3'h4,
    S_ACK     = 3'h5,
    S_TX      = 3'h6,
    S_TX_ACK  = 3'h7
  } bus_state_type;

  // next write location, wrapping inside the 16-byte page
  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + PAGE_W'(1)};
  endfunction

endpackage

// *** design/line_filter.sv ***
/*
  Two-flop synchroniser and glitch rejector for the scl and sda pins.
  Assumes idle-high lines; a change passes only after it has held steadily.
*/
module line_filter (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // raw pins and cleaned levels
  input  wire eeprom_pkg::line_type i_raw,
  output eeprom_pkg::line_type      o_clean
);

  typedef struct packed {
    eeprom_pkg::line_type                   meta;
    eeprom_pkg::line_type                   sync;
    eeprom_pkg::line_type                   clean;
    logic [1:0][eeprom_pkg::GLITCH_CW-1:0]  cnt;
  } filt_state_type;

  filt_state_type r_reg;
  filt_state_type r_next;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next      = r_reg;
    r_next.meta = i_raw;
    r_next.sync = r_reg.meta;
    for (int i = 0; i < 2; i++) begin
      if (r_reg.sync[i] == r_reg.clean[i]) begin
        r_next.cnt[i] = '0;
      end else if (r_reg.cnt[i] == eeprom_pkg::GLITCH_CW'(eeprom_pkg::GLITCH_CYCLES - 1)) begin
        r_next.clean[i] = r_reg.sync[i];
        r_next.cnt[i]   = '0;
      end else begin
        r_next.cnt[i] = r_reg.cnt[i] + eeprom_pkg::GLITCH_CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '{meta: 2'h3, sync: 2'h3, clean: 2'h3, cnt: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_clean = r_reg.clean;

endmodule

// *** design/sync_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides and a flush.
  Assumes one clock; DEPTH is a power of two.
*/
module sync_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  // clock, reset and flush
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_flush,
  // fill side
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // drain side
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);

  localparam int PW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
  } fifo_state_type;

  fifo_state_type   r_reg;
  fifo_state_type   r_next;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic             push;
  logic             pop;

  assign o_rd_valid = (r_reg.wp != r_reg.rp);
  assign o_wr_ready = ((r_reg.wp - r_reg.rp) != PW'(DEPTH));
  assign o_rd_data  = store[r_reg.rp[PW-2:0]];
  assign push       = i_wr_valid & o_wr_ready & ~i_flush;
  assign pop        = i_rd_ready & o_rd_valid & ~i_flush;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    if (i_flush) begin
      r_next.rp = r_reg.wp;
    end else begin
      if (push) begin
        r_next.wp = r_reg.wp + PW'(1);
      end
      if (pop) begin
        r_next.rp = r_reg.rp + PW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      store[r_reg.wp[PW-2:0]] <= i_wr_data;
    end
  end

endmodule

// *** verification/eeprom_slave_monitor.sv ***
/*
  Pin-level checker for the eeprom slave, bound to every instance.
  Assumes sda_i is the resolved wire (pull-up, slave and master).
*/
module eeprom_slave_monitor #(
  parameter int WRITE_CYCLES = 500000
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda_i,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned busy_cnt;
  logic [3:0]  since_stop;
  logic        sda_q;

  // raw stop at the pins; the slave only sees it after sync and filter
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_cnt   <= 0;
      since_stop <= 4'hf;
      sda_q      <= 1'b1;
    end else begin
      busy_cnt <= o_busy ? busy_cnt + 1 : 0;
      sda_q    <= i_sda_i;
      if (i_scl && i_sda_i && !sda_q) begin
        since_stop <= 4'h0;
      end else if (since_stop != 4'hf) begin
        since_stop <= since_stop + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_quiet2;
    (!o_sda_oe && !o_busy) [*2];
  endsequence
  sequence s_scl_high2;
    i_scl [*2];
  endsequence

  property p_open_drain;
    o_sda_oe |-> o_sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high");
  property p_reset_quiet;
    $rose(i_rst_b) |-> s_quiet2;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_change_on_low;
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 4);
  endproperty
  a_change_on_low: assert property (p_change_on_low)
    else $error("sda changed outside scl low");
  property p_hold_bit;
    $changed(o_sda_oe) |=> $stable(o_sda_oe) [*8];
  endproperty
  a_hold_bit: assert property (p_hold_bit)
    else $error("driven sda bit too short");
  property p_still_high;
    s_scl_high2 |-> $stable(o_sda_oe);
  endproperty
  a_still_high: assert property (p_still_high)
    else $error("sda changed while scl high");
  property p_busy_bound;
    o_busy |-> busy_cnt < WRITE_CYCLES;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("programming too long");
  property p_busy_after_stop;
    $rose(o_busy) |-> since_stop < 4'hc;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("programming without stop");
  property p_busy_silent;
    o_busy |-> !o_sda_oe;
  endproperty
  a_busy_silent: assert property (p_busy_silent)
    else $error("acknowledge while programming");
endmodule

bind eeprom_slave eeprom_slave_monitor #(
  .WRITE_CYCLES (WRITE_CYCLES)
) i_monitor (
  .i_clk    (i_clk),
  .i_rst_b  (i_rst_b),
  .i_scl    (i_scl),
  .i_sda_i  (i_sda_i),
  .o_sda_o  (o_sda_o),
  .o_sda_oe (o_sda_oe),
  .o_busy   (o_busy)
);

// *** verification/i2c_master_model.sv ***
/*
  Behavioural two-wire bus master: start, stop, byte write and read.
  Assumes the bench resolves sda with a pull-up; scl idles high between frames.
*/
module i2c_master_model (
  // bus lines
  output logic      o_scl,
  output logic      o_sda,
  input  wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // scl low 320 ns: the slave answers some 110 ns after a fall
  task automatic bit_io(input logic b, input logic g, output logic s);
    #100 o_sda = b;
    #100;
    if (g) begin
      o_scl = 1'b1; // 40 ns pulse, below the reject width
      #40 o_scl = 1'b0;
      #80;
    end else begin
      #120;
    end
    o_scl = 1'b1;
    #80 s = i_sda;
    #80 o_scl = 1'b0;
  endtask

  // a repeated start must wait out the slave's ack release before scl rises,
  // or the release would read as a stop while scl is high
  task automatic start();
    #100 o_sda = 1'b1;
    #220 o_scl = 1'b1;
    #300 o_sda = 1'b0;
    #300 o_scl = 1'b0;
  endtask

  task automatic stop();
    #100 o_sda = 1'b0;
    #220 o_scl = 1'b1;
    #300 o_sda = 1'b1;
    #300;
  endtask

  task automatic wbyte(input logic [7:0] b, input logic g, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g, s);
    bit_io(1'b1, 1'b0, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, 1'b0, b[i]);
    bit_io(nack, 1'b0, s);
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  Self-checking bench for the eeprom slave in its two-byte address variant.
  Assumes the master model for bus traffic and a shortened programming time.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         WCYC = 1000;
  localparam logic [3:0] TYPE = 4'h9; // arbitrary value
  localparam logic [2:0] SEL  = 3'h5;
  typedef struct packed {
    logic [10:0] a;
    logic [7:0]  d;
    logic        g;
    logic        wp;
    logic [7:0]  e;
  } row_type;
  row_type    rows [4] = '{'{11'h000, 8'h3c, 1'b0, 1'b0, 8'h3c},
                           '{11'h7ff, 8'ha5, 1'b1, 1'b0, 8'ha5},
                           '{11'h400, 8'h81, 1'b0, 1'b0, 8'h81},
                           '{11'h7ff, 8'h11, 1'b0, 1'b1, 8'ha5}};
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       wp = 1'b0;
  logic       scl;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic       ack;
  logic [7:0] rd;
  wire        sda_wire = (sda_oe ? sda_o : 1'b1) & sda_m;
  int         bad_count = 0;
  int         compares = 0;
  int         cycles = 0;

  always #10 clk = ~clk;

  eeprom_slave #(
    .VARIANT      (eeprom_pkg::VAR_2K_WIDE),
    .TYPE_CODE    (TYPE),
    .WRITE_CYCLES (WCYC)
  ) i_dut (
    .i_clk           (clk),
    .i_rst_b         (rst_b),
    .i_scl           (scl),
    .i_sda_i         (sda_wire),
    .o_sda_o         (sda_o),
    .o_sda_oe        (sda_oe),
    .i_select_pin_0  (SEL[0]),
    .i_select_pin_1  (SEL[1]),
    .i_select_pin_2  (SEL[2]),
    .i_write_protect (wp),
    .o_busy          (busy)
  );
  i2c_master_model i_master (.o_scl(scl), .o_sda(sda_m), .i_sda(sda_wire));

  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic dev(input logic [7:0] b);
    i_master.start();
    i_master.wbyte(b, 1'b0, ack);
  endtask

  task automatic put_ptr(input logic [10:0] a);
    dev({TYPE, SEL, 1'b0});
    check(ack, 1'b1);
    i_master.wbyte({5'h00, a[10:8]}, 1'b0, ack);
    check(ack, 1'b1);
    i_master.wbyte(a[7:0], 1'b0, ack);
    check(ack, 1'b1);
  endtask

  // bounded wait: a hung busy flag must not stall the run
  task automatic wait_prog(input logic chk);
    int n;
    n = 0;
    if (chk) check(busy, 1'b1);
    while (busy === 1'b1 && n < WCYC + 20) begin
      @(negedge clk);
      n++;
    end
    check(busy, 1'b0);
  endtask

  task automatic rd_chk(input logic [10:0] a, input logic [7:0] e);
    put_ptr(a);
    dev({TYPE, SEL, 1'b1});
    check(ack, 1'b1);
    i_master.rbyte(1'b1, rd);
    i_master.stop();
    check(rd, e);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    check(sda_oe, 1'b0);
    check(busy, 1'b0);
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    $display("test reset done");
    foreach (rows[i]) begin
      @(negedge clk);
      wp = rows[i].wp;
      put_ptr(rows[i].a);
      i_master.wbyte(rows[i].d, rows[i].g, ack);
      check(ack, 1'b1);
      i_master.stop();
      wait_prog(!rows[i].wp);
      @(negedge clk);
      wp = 1'b0;
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("test rows done");
    put_ptr(11'h1f8);
    for (int i = 0; i < 16; i++) begin
      i_master.wbyte(8'h40 + 8'(i), 1'b0, ack);
      check(ack, 1'b1);
    end
    i_master.stop();
    dev({TYPE, SEL, 1'b0});
    check(ack, 1'b0);
    i_master.stop();
    wait_prog(1'b0);
    put_ptr(11'h1f0);
    dev({TYPE, SEL, 1'b1});
    for (int i = 0; i < 16; i++) begin
      i_master.rbyte(i == 15, rd);
      check(rd, 8'h40 + 8'((i + 8) % 16));
    end
    i_master.stop();
    $display("test page done");
    put_ptr(11'h000);
    i_master.wbyte(8'hee, 1'b0, ack);
    rd_chk(11'h000, 8'h3c);
    check(busy, 1'b0);
    $display("test discard done");
    for (int k = 0; k < 4; k++) begin
      dev(k < 3 ? {TYPE, SEL ^ (3'h1 << k), 1'b1} : {~TYPE, SEL, 1'b0});
      check(ack, 1'b0);
      i_master.stop();
    end
    $display("test mismatch done");
    finish_test();
  end
endmodule
